// [common/tmsr_pkg.sv]
package tmsr_pkg;

  localparam int unsigned KEYS      = 64;
  localparam logic [7:0]  ADDR_CMD  = 8'h00;
  localparam logic [7:0]  ADDR_RESP = 8'h04;
  localparam logic [7:0]  ADDR_STAT = 8'h08;
  localparam logic [7:0]  ADDR_WIN  = 8'h0C;

  localparam logic [7:0] CMD_STATUS = 8'h37;
  localparam logic [7:0] CMD_G_SIG  = 8'h20;
  localparam logic [7:0] CMD_G_DLT  = 8'h21;
  localparam logic [7:0] CMD_G_REF  = 8'h22;
  localparam logic [7:0] CMD_G_OFS  = 8'h23;
  localparam logic [7:0] CMD_G_CZ   = 8'h24;
  localparam logic [7:0] CMD_G_INT  = 8'h25;
  localparam logic [7:0] CMD_K_ERR  = 8'h65;
  localparam logic [7:0] CMD_G_ERR  = 8'h45;
  localparam logic [7:0] CMD_FIRST  = 8'h6B;
  localparam logic [7:0] CMD_SC_KEY = 8'h73;
  localparam logic [7:0] CMD_SC_ALL = 8'h53;
  localparam logic [7:0] CMD_SC_ROW = 8'h78;
  localparam logic [7:0] CMD_SC_COL = 8'h79;

  // Per-key memory word: five byte fields.
  localparam logic [2:0] FLD_SIG = 3'h0;
  localparam logic [2:0] FLD_REF = 3'h1;
  localparam logic [2:0] FLD_OFS = 3'h2;
  localparam logic [2:0] FLD_CZ  = 3'h3;
  localparam logic [2:0] FLD_INT = 3'h4;
  localparam int unsigned FLDS   = 5;

  // Status byte bit positions.
  localparam int unsigned ST_DET  = 0;
  localparam int unsigned ST_RCL  = 1;
  localparam int unsigned ST_ERR  = 2;
  localparam int unsigned ST_SYNC = 3;
  localparam int unsigned ST_STOR = 4;

  localparam logic [7:0] REF_DRIFT_HI = 8'hBF;
  localparam logic [7:0] REF_DRIFT_LO = 8'h40;
  localparam logic [7:0] CZ_MAX       = 8'h03;
  localparam logic [7:0] NO_KEY       = 8'hFF;
  localparam logic [7:0] WIN_HI_RST   = 8'hF0;
  localparam logic [7:0] WIN_LO_RST   = 8'h10;
  localparam int unsigned RECAL_TRIES = 5;

  typedef enum logic [2:0] {SC_NONE, SC_KEY, SC_ROW, SC_COL, SC_ALL} scope_t;

endpackage

// [common/key_mem_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface key_mem_if;
  logic        wr_en;
  logic [5:0]  wr_key;
  logic [2:0]  wr_field;
  logic [7:0]  wr_data;
  logic [5:0]  rd_key;
  logic [39:0] rd_data;
  modport owner (output wr_en, wr_key, wr_field, wr_data, rd_key, input rd_data);
  modport store (input wr_en, wr_key, wr_field, wr_data, rd_key, output rd_data);
endinterface
`default_nettype wire

// [hw/key_mem.sv]
`timescale 1ns/10ps
`default_nettype none
module key_mem
  import tmsr_pkg::*;
(
  input  wire logic pclk,     // Clock.
  input  wire logic presetn,  // Asynchronous reset, active low.
  input  wire logic clk_en,   // Freezes all state while low.
  key_mem_if.store  mem       // Access port.
);

  typedef struct packed {
    logic [KEYS-1:0][FLDS*8-1:0] arr;
    logic [FLDS*8-1:0]           rdata;
  } mem_st_t;

  mem_st_t s_q;
  mem_st_t s_d;

  always_comb begin
    s_d = s_q;
    if (mem.wr_en) begin
      s_d.arr[mem.wr_key][mem.wr_field*8 +: 8] = mem.wr_data;
    end
    s_d.rdata = s_q.arr[mem.rd_key];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign mem.rd_data = s_q.rdata;

endmodule
`default_nettype wire

// [hw/touch_matrix_status_responder.sv]
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// RULE1 - Status byte: five low bits, upper zero
// RULE2 - Bit0 any detect, bit1 any recalibrating
// RULE3 - Bit2 any error, bit3 lost external sync
// RULE4 - Bit4 setup store disagrees with backup
// RULE5 - Signal group: 8 row/column, else 64
// RULE6 - Delta group: reference minus signal, saturated
// RULE7 - Reference group sized by scope
// RULE8 - Offset group sized by scope
// RULE9 - Cancellation group clipped to 0..3
// RULE10 - Integrator group sized by scope
// RULE11 - Key error byte: fail, recal, high, low
// RULE12 - Five failed attempts before fail flag
// RULE13 - Recal start clears high and low flags
// RULE14 - High flag: drift above 191 or window
// RULE15 - Low flag: drift below 64 or window
// RULE16 - Group error: one byte, eight for matrix
// RULE17 - Error bitmap ordering by row/column/byte
// RULE18 - Bitmap one means key has error
// RULE19 - First key: number bits, bit7 others active
// RULE20 - No detected key returns 255
// RULE21 - Dropped first key replaced by another
// RULE22 - Key number is row plus eight times column
// RULE23 - Scope commands select key, row, column, all
// RULE24 - 64-byte groups ascend from key zero
module touch_matrix_status_responder
  import tmsr_pkg::*;
#(
  parameter int unsigned TRIES = RECAL_TRIES
) (
  input  wire logic        pclk,         // Clock, 250 MHz.
  input  wire logic        presetn,      // Asynchronous reset, active low.
  input  wire logic        clk_en,       // Freezes all state while low.
  input  wire logic [7:0]  paddr,        // APB byte address.
  input  wire logic        psel,         // APB select.
  input  wire logic        penable,      // APB enable.
  input  wire logic        pwrite,       // APB direction.
  input  wire logic [31:0] pwdata,       // APB write data.
  output logic      [31:0] prdata,       // APB read data.
  output logic             pready,       // APB ready.
  output logic             pslverr,      // APB error for unmapped word.
  input  wire logic [63:0] key_detect,   // Keys now in detection.
  input  wire logic        kw_en,        // Sensing engine writes a key field.
  input  wire logic [5:0]  kw_key,       // Key of that write.
  input  wire logic [2:0]  kw_field,     // Field of that write.
  input  wire logic [7:0]  kw_data,      // Value of that write.
  input  wire logic        cal_start,    // Full recalibration attempt begins.
  input  wire logic        cal_done,     // Attempt finished.
  input  wire logic        cal_ok,       // Attempt succeeded, with cal_done.
  input  wire logic [5:0]  cal_key,      // Key being recalibrated.
  input  wire logic [7:0]  cal_level,    // Absolute reference after attempt.
  input  wire logic        ext_sync_mode, // External sync mode active.
  input  wire logic        sync_locked,  // Locked to the external source.
  input  wire logic        store_mismatch, // Setup store differs from backup.
  output logic             cal_retry     // Pulse: start another attempt.
);

  generate
    if (TRIES < 1 || TRIES > 7) begin : g_bad_tries
      $error("TRIES must lie in 1..7");
    end
  endgenerate

  typedef enum logic [1:0] {E_IDLE, E_FETCH, E_LOAD, E_HOLD} eng_t;

  typedef struct packed {
    logic [63:0] f_fail;
    logic [63:0] f_recal;
    logic [63:0] f_high;
    logic [63:0] f_low;
    logic [2:0]  tries;
    logic        retry;
    logic        first_ok;
    logic [5:0]  first;
    scope_t      scope;
    logic [2:0]  row;
    logic [2:0]  col;
    logic [7:0]  win_hi;
    logic [7:0]  win_lo;
    logic [7:0]  cmd;
    logic [6:0]  left;
    logic [5:0]  idx;
    eng_t        eng;
    logic [7:0]  resp;
    logic        bad;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } st_t;

  st_t s_q;
  st_t s_d;

  key_mem_if mif ();

  key_mem u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .mem     (mif.store)
  );

  // Key number of the idx-th byte of a group answer.
  function automatic logic [5:0] key_at(scope_t sc, logic [2:0] r, logic [2:0] c,
                                        logic [5:0] i);
    case (sc)
      SC_ROW:  key_at = {i[2:0], r};                 // see RULE22
      SC_COL:  key_at = {c, i[2:0]};
      default: key_at = i;                           // see RULE24
    endcase
  endfunction

  function automatic logic [3:0] err_nib(st_t s, logic [5:0] k);
    err_nib = {s.f_low[k], s.f_high[k], s.f_recal[k], s.f_fail[k]}; // see RULE11
  endfunction

  function automatic logic [5:0] lowest(logic [63:0] v);
    lowest = 6'h00;
    for (int i = 63; i >= 0; i--) begin
      if (v[i]) begin
        lowest = 6'(i);
      end
    end
  endfunction

  function automatic logic is_mem_cmd(logic [7:0] c);
    is_mem_cmd = (c >= CMD_G_SIG) && (c <= CMD_G_INT);
  endfunction

  logic [63:0] any_err;
  logic [7:0]  gen_status;
  logic [7:0]  delta;
  logic [7:0]  mem_byte;
  logic [7:0]  dir_byte;
  logic [7:0]  rd_ref;
  logic [5:0]  sel_key;
  logic        pop;
  logic        access;

  assign any_err = s_q.f_fail | s_q.f_recal | s_q.f_high | s_q.f_low; // see RULE18
  assign sel_key = {s_q.col, s_q.row};               // see RULE23
  assign rd_ref  = mif.rd_data[FLD_REF*8 +: 8];

  always_comb begin
    gen_status          = 8'h00;                     // see RULE1
    gen_status[ST_DET]  = |key_detect;               // see RULE2
    gen_status[ST_RCL]  = |s_q.f_recal;
    gen_status[ST_ERR]  = |any_err;                  // see RULE3
    gen_status[ST_SYNC] = ext_sync_mode & ~sync_locked;
    gen_status[ST_STOR] = store_mismatch;            // see RULE4
  end

  always_comb begin
    delta = (rd_ref > mif.rd_data[FLD_SIG*8 +: 8]) ?
            8'(rd_ref - mif.rd_data[FLD_SIG*8 +: 8]) : 8'h00; // see RULE6
    case (s_q.cmd)
      CMD_G_SIG: mem_byte = mif.rd_data[FLD_SIG*8 +: 8];       // see RULE5
      CMD_G_DLT: mem_byte = delta;
      CMD_G_REF: mem_byte = rd_ref;                            // see RULE7
      CMD_G_OFS: mem_byte = mif.rd_data[FLD_OFS*8 +: 8];       // see RULE8
      CMD_G_CZ: begin
        mem_byte = mif.rd_data[FLD_CZ*8 +: 8];
        if (mem_byte > CZ_MAX) begin
          mem_byte = CZ_MAX;                                   // see RULE9
        end
      end
      default:   mem_byte = mif.rd_data[FLD_INT*8 +: 8];       // see RULE10
    endcase
  end

  // Byte for the commands answered from flags, at index s_d.idx.
  function automatic logic [7:0] direct(st_t s, logic [7:0] c, logic [5:0] i,
                                        logic [63:0] det, logic [63:0] er,
                                        logic [7:0] gs);
    direct = 8'h00;
    case (c)
      CMD_STATUS: direct = gs;
      CMD_K_ERR:  direct = {4'h0, err_nib(s, {s.col, s.row})};
      CMD_FIRST: begin
        if (!s.first_ok) begin
          direct = NO_KEY;                                     // see RULE20
        end else begin
          direct = {|(det & ~(64'h1 << s.first)), 1'b0, s.first}; // see RULE19
        end
      end
      CMD_G_ERR: begin
        for (int n = 0; n < 8; n++) begin
          case (s.scope)
            SC_ROW:  direct[n] = er[{3'(n), s.row}];           // see RULE17
            SC_COL:  direct[n] = er[{s.col, 3'(n)}];
            SC_KEY:  direct = {4'h0, err_nib(s, {s.col, s.row})}; // see RULE16
            default: direct[n] = er[{i[2:0], 3'(n)}];
          endcase
        end
      end
      default: direct = 8'h00;
    endcase
  endfunction

  assign access = psel & penable & s_q.pready;
  assign pop    = access & ~pwrite & (paddr == ADDR_RESP) & s_q.prdata[8];

  always_comb begin
    s_d = s_q;
    dir_byte = 8'h00;

    // First-touched key tracking.
    if (!(|key_detect)) begin
      s_d.first_ok = 1'b0;
    end else if (!s_q.first_ok || !key_detect[s_q.first]) begin
      s_d.first_ok = 1'b1;
      s_d.first    = lowest(key_detect);             // see RULE21
    end

    // Recalibration attempts.
    s_d.retry = 1'b0;
    if (cal_start) begin
      s_d.f_recal[cal_key] = 1'b1;                   // see RULE13
      s_d.f_high[cal_key]  = 1'b0;
      s_d.f_low[cal_key]   = 1'b0;
      if (!s_q.retry) begin
        s_d.tries = 3'h0;
      end
    end else if (cal_done) begin
      s_d.f_recal[cal_key] = 1'b0;
      if (cal_ok) begin
        s_d.f_fail[cal_key] = 1'b0;
        s_d.f_high[cal_key] = cal_level > s_q.win_hi; // see RULE14
        s_d.f_low[cal_key]  = cal_level < s_q.win_lo; // see RULE15
      end else if (32'(s_q.tries) + 32'd1 >= TRIES) begin
        s_d.f_fail[cal_key] = 1'b1;                  // see RULE12
      end else begin
        s_d.tries            = 3'(s_q.tries + 3'h1);
        s_d.f_recal[cal_key] = 1'b1;
        s_d.retry            = 1'b1;
      end
    end

    // Drift checks come after the recalibration updates so that a drift set wins a clear.
    if (kw_en && kw_field == FLD_REF) begin
      if (kw_data > REF_DRIFT_HI) begin
        s_d.f_high[kw_key] = 1'b1;                   // see RULE14
      end
      if (kw_data < REF_DRIFT_LO) begin
        s_d.f_low[kw_key] = 1'b1;                    // see RULE15
      end
    end

    // Answer engine.
    case (s_q.eng)
      E_FETCH: s_d.eng = E_LOAD;
      E_LOAD: begin
        s_d.resp = mem_byte;
        s_d.eng  = E_HOLD;
      end
      E_HOLD: begin
        if (pop) begin
          s_d.left = 7'(s_q.left - 7'h01);
          s_d.idx  = 6'(s_q.idx + 6'h01);
          if (s_q.left == 7'h01) begin
            s_d.eng = E_IDLE;
          end else if (is_mem_cmd(s_q.cmd)) begin
            s_d.eng = E_FETCH;
          end else begin
            s_d.resp = direct(s_q, s_q.cmd, s_d.idx, key_detect, any_err, gen_status);
          end
        end
      end
      default: s_d.eng = E_IDLE;
    endcase

    // APB: a write takes effect at the access edge.
    if (access && pwrite) begin
      case (paddr)
        ADDR_CMD: begin
          s_d.cmd  = pwdata[7:0];
          s_d.idx  = 6'h00;
          s_d.bad  = 1'b0;
          s_d.eng  = E_IDLE;
          s_d.left = 7'h00;
          case (pwdata[7:0])
            CMD_SC_KEY: begin
              s_d.scope = SC_KEY;                    // see RULE23
              s_d.row   = pwdata[10:8];
              s_d.col   = pwdata[13:11];
            end
            CMD_SC_ALL: s_d.scope = SC_ALL;
            CMD_SC_ROW: begin
              s_d.scope = SC_ROW;
              s_d.row   = pwdata[10:8];
            end
            CMD_SC_COL: begin
              s_d.scope = SC_COL;
              s_d.col   = pwdata[10:8];
            end
            CMD_G_SIG, CMD_G_DLT, CMD_G_REF, CMD_G_OFS, CMD_G_CZ, CMD_G_INT: begin
              s_d.left = (s_q.scope == SC_ROW || s_q.scope == SC_COL) ?
                         7'h08 : 7'h40;              // see RULE5
              s_d.eng  = E_FETCH;
            end
            CMD_G_ERR: begin
              s_d.left = (s_q.scope == SC_ALL || s_q.scope == SC_NONE) ?
                         7'h08 : 7'h01;              // see RULE16
              s_d.eng  = E_HOLD;
            end
            CMD_STATUS, CMD_K_ERR, CMD_FIRST: begin
              s_d.left = 7'h01;
              s_d.eng  = E_HOLD;
            end
            default: s_d.bad = 1'b1;
          endcase
          if (s_d.eng == E_HOLD) begin
            dir_byte = direct(s_d, pwdata[7:0], 6'h00, key_detect, any_err, gen_status);
            s_d.resp = dir_byte;
          end
        end
        ADDR_WIN: begin
          s_d.win_hi = pwdata[7:0];
          s_d.win_lo = pwdata[15:8];
        end
        default: s_d.bad = s_q.bad;
      endcase
    end

    // Read data and ready are formed in the setup cycle so they leave flip-flops.
    s_d.pready  = psel & ~penable;
    s_d.pslverr = 1'b0;
    s_d.prdata  = 32'h0000_0000;
    if (psel && !penable) begin
      case (paddr)
        ADDR_CMD:  s_d.prdata = {24'h00_0000, s_q.cmd};
        ADDR_RESP: s_d.prdata = {23'h00_0000, s_q.eng == E_HOLD, s_q.resp};
        ADDR_STAT: s_d.prdata = {16'h0000, gen_status, s_q.eng != E_IDLE, s_q.left};
        ADDR_WIN:  s_d.prdata = {16'h0000, s_q.win_lo, s_q.win_hi};
        default:   s_d.pslverr = 1'b1;
      endcase
      if (paddr == ADDR_STAT) begin
        s_d.prdata[16] = s_q.bad;
      end
    end
  end

  assign mif.wr_en    = kw_en;
  assign mif.wr_key   = kw_key;
  assign mif.wr_field = kw_field;
  assign mif.wr_data  = kw_data;
  assign mif.rd_key   = key_at(s_q.scope, s_q.row, s_q.col, s_q.idx);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q        <= '0;
      s_q.scope  <= SC_NONE;
      s_q.eng    <= E_IDLE;
      s_q.win_hi <= WIN_HI_RST;
      s_q.win_lo <= WIN_LO_RST;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign prdata    = s_q.prdata;
  assign pready    = s_q.pready;
  assign pslverr   = s_q.pslverr;
  assign cal_retry = s_q.retry;

endmodule
`default_nettype wire

// [sim/tmsr_chk.sv]
`timescale 1ns/10ps
`default_nettype none
module tmsr_chk
  import tmsr_pkg::*;
(
  input wire logic        pclk,          // Clock.
  input wire logic        presetn,       // Reset, active low.
  input wire logic        psel,          // Select.
  input wire logic        penable,       // Enable.
  input wire logic        pwrite,        // Direction.
  input wire logic [7:0]  paddr,         // Address.
  input wire logic [31:0] prdata,        // Read data.
  input wire logic        pready,        // Ready.
  input wire logic        pslverr,       // Error.
  input wire logic        cal_start,     // Attempt begins.
  input wire logic        cal_done,      // Attempt ends.
  input wire logic        cal_ok,        // Attempt result.
  input wire logic        cal_retry,     // Retry pulse.
  input wire logic        store_mismatch // Store flag input.
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  ready_setup_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  error_empty_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer carries data");
  status_upper_a: assert property (
    pready && !pwrite && paddr == ADDR_STAT |-> prdata[15:13] == 3'h0)
    else $error("status upper bits set");
  store_flag_a: assert property (
    pready && !pwrite && paddr == ADDR_STAT && $stable(store_mismatch)
    && $past(store_mismatch, 3) == store_mismatch |-> prdata[12] == store_mismatch)
    else $error("store flag wrong");
  retry_pulse_a: assert property (cal_retry |=> !cal_retry)
    else $error("retry longer than one cycle");
  retry_cause_a: assert property (
    cal_retry |-> $past(cal_done) && !$past(cal_ok) && !$past(cal_start))
    else $error("retry without failed attempt");
  retry_start_a: assert property (cal_start |=> !cal_retry)
    else $error("retry right after a start");
endmodule

bind touch_matrix_status_responder tmsr_chk i_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .cal_start, .cal_done, .cal_ok, .cal_retry, .store_mismatch
);
`default_nettype wire

// [sim/sense_engine_model.sv]
`timescale 1ns/10ps
`default_nettype none
module sense_engine_model (
  input  wire logic       pclk,      // Clock.
  input  wire logic       cal_retry, // Retry request.
  output logic            kw_en,     // Field write strobe.
  output logic [5:0]      kw_key,    // Key written.
  output logic [2:0]      kw_field,  // Field written.
  output logic [7:0]      kw_data,   // Value written.
  output logic            cal_start, // Attempt begins.
  output logic            cal_done,  // Attempt ends.
  output logic            cal_ok,    // Attempt result.
  output logic [5:0]      cal_key,   // Key under calibration.
  output logic [7:0]      cal_level  // Reference after attempt.
);
  logic go = 1'b0;
  int   left = 0;
  int   starts = 0;
  initial begin
    {kw_en, kw_key, kw_field, kw_data, cal_done, cal_ok, cal_key, cal_level} = '0;
  end
  // A retry is answered in its own cycle so the block keeps its attempt count.
  assign cal_start = go | cal_retry;
  always @(posedge pclk) begin
    cal_done <= 1'b0;
    if (cal_start) begin
      starts <= starts + 1;
      left <= 40;
    end else if (left > 0) begin
      left <= left - 1;
      cal_done <= (left == 1);
    end
  end
  task automatic put(input int k, input int f, input logic [7:0] d);
    @(posedge pclk);
    kw_en <= 1'b1;
    kw_key <= 6'(k);
    kw_field <= 3'(f);
    kw_data <= d;
    @(posedge pclk);
    kw_en <= 1'b0;
    kw_data <= ~d;
  endtask
  task automatic recal(input int k, input logic ok, input logic [7:0] lv);
    @(posedge pclk);
    go <= 1'b1;
    cal_key <= 6'(k);
    cal_ok <= ok;
    cal_level <= lv;
    @(posedge pclk);
    go <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [sim/touch_matrix_status_responder_test.sv]
`timescale 1ns/10ps
`default_nettype none
module touch_matrix_status_responder_test
  import tmsr_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [63:0] key_detect = 64'h0;
  logic        ext_sync_mode = 1'b0;
  logic        sync_locked = 1'b0;
  logic        store_mismatch = 1'b0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, kw_en, cal_start, cal_done, cal_ok, cal_retry;
  logic [5:0]  kw_key, cal_key;
  logic [2:0]  kw_field;
  logic [7:0]  kw_data, cal_level, b;
  logic [63:0] bad;
  int          errors = 0;
  int          tests_run = 0;
  int          n0;

  always #2 pclk = ~pclk;

  touch_matrix_status_responder i_dut (
    .pclk, .presetn, .clk_en(1'b1), .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .key_detect, .kw_en, .kw_key, .kw_field, .kw_data, .cal_start,
    .cal_done, .cal_ok, .cal_key, .cal_level, .ext_sync_mode, .sync_locked,
    .store_mismatch, .cal_retry
  );
  sense_engine_model u_eng (
    .pclk, .cal_retry, .kw_en, .kw_key, .kw_field, .kw_data, .cal_start, .cal_done,
    .cal_ok, .cal_key, .cal_level
  );

  task automatic wrap_up();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic fail();
    errors++;
    $display("[ERR] %0t wait timed out", $time);
    wrap_up();
  endtask
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fail();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic cmd(input logic [7:0] c, input logic [7:0] a);
    xfer(1'b1, ADDR_CMD, {16'h0, a, c});
  endtask
  task automatic get(output logic [7:0] v);
    int n;
    n = 0;
    do begin
      xfer(1'b0, ADDR_RESP, 32'h0);
      n++;
    end while (rd[8] !== 1'b1 && n < 20);
    if (n >= 20) fail();
    v = rd[7:0];
  endtask
  task automatic nomore();
    xfer(1'b0, ADDR_RESP, 32'h0);
    check(8'(rd[8]), 8'h00);
  endtask
  task automatic ask(input logic [7:0] c, input logic [7:0] e);
    cmd(c, 8'h00);
    get(b);
    check(b, e);
  endtask
  task automatic kerr(input logic [7:0] k, input logic [7:0] e);
    cmd(CMD_SC_KEY, k);
    ask(CMD_K_ERR, e);
  endtask
  task automatic settle();
    int q;
    q = 0;
    for (int i = 0; i < 2000 && q < 4; i++) begin
      @(posedge pclk);
      q = (u_eng.left == 0 && cal_retry === 1'b0) ? q + 1 : 0;
    end
    if (q < 4) fail();
  endtask
  function automatic logic [7:0] raw(input int f, input int k);
    case (f)
      0: return 8'(4 * k);
      1: return 8'h80;
      2: return 8'(k) ^ 8'h5A;
      3: return 8'(k);
      default: return 8'(63 - k);
    endcase
  endfunction
  function automatic logic [7:0] want(input int c, input int k);
    if (c == 1)
      return (raw(0, k) < 8'h80) ? 8'h80 - raw(0, k) : 8'h00;
    if (c == 4)
      return (k > 3) ? 8'h03 : 8'(k);
    return raw((c == 0) ? 0 : c - 1, k);
  endfunction
  function automatic int kidx(input int s, input int i);
    if (s == 2)
      return 3 + 8 * i;
    if (s == 3)
      return 40 + i;
    return i;
  endfunction

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    ask(CMD_STATUS, 8'h00);
    key_detect <= 64'h20;
    store_mismatch <= 1'b1;
    ext_sync_mode <= 1'b1;
    ask(CMD_STATUS, 8'h19);
    cmd(8'h7F, 8'h00);
    xfer(1'b0, ADDR_STAT, 32'h0);
    check(rd[15:8], 8'h19);
    check(rd[7:0], 8'h00);
    check(8'(rd[23:16]), 8'h01);
    xfer(1'b0, ADDR_CMD, 32'h0);
    check(rd[7:0], 8'h7F);
    sync_locked <= 1'b1;
    key_detect <= 64'h0;
    store_mismatch <= 1'b0;
    ask(CMD_STATUS, 8'h00);
    xfer(1'b0, 8'h10, 32'h0);
    check({7'h0, err}, 8'h01);
    xfer(1'b0, ADDR_WIN, 32'h0);
    check(rd[7:0], WIN_HI_RST);
    check(rd[15:8], WIN_LO_RST);
    xfer(1'b1, ADDR_WIN, 32'h0000_55AA);
    xfer(1'b0, ADDR_WIN, 32'h0);
    check(rd[7:0], 8'hAA);
    check(rd[15:8], 8'h55);
    xfer(1'b1, ADDR_WIN, {16'h0, WIN_LO_RST, WIN_HI_RST});
    for (int k = 0; k < 64; k++)
      for (int f = 0; f < 5; f++)
        u_eng.put(k, f, raw(f, k));
    // Scopes in turn: none, key 9, row 3, column 5, whole matrix.
    for (int s = 0; s < 5; s++) begin
      if (s == 1) cmd(CMD_SC_KEY, 8'h09);
      if (s == 2) cmd(CMD_SC_ROW, 8'h03);
      if (s == 3) cmd(CMD_SC_COL, 8'h05);
      if (s == 4) cmd(CMD_SC_ALL, 8'h00);
      for (int c = 0; c < 6; c++) begin
        cmd(CMD_G_SIG + 8'(c), 8'h00);
        for (int i = 0; i < ((s == 2 || s == 3) ? 8 : 64); i++) begin
          get(b);
          check(b, want(c, kidx(s, i)));
        end
        nomore();
      end
    end
    u_eng.put(10, 1, 8'hC0);
    u_eng.put(11, 1, 8'hBF);
    u_eng.put(20, 1, 8'h3F);
    u_eng.put(21, 1, 8'h40);
    kerr(8'h0A, 8'h04);
    kerr(8'h0B, 8'h00);
    kerr(8'h14, 8'h08);
    kerr(8'h15, 8'h00);
    u_eng.recal(10, 1'b1, 8'h80);
    kerr(8'h0A, 8'h02);
    ask(CMD_STATUS, 8'h06);
    settle();
    kerr(8'h0A, 8'h00);
    u_eng.recal(40, 1'b1, 8'hF8);
    settle();
    u_eng.recal(41, 1'b1, 8'h08);
    settle();
    u_eng.recal(42, 1'b1, 8'hF0);
    settle();
    kerr(8'h28, 8'h04);
    kerr(8'h29, 8'h08);
    kerr(8'h2A, 8'h00);
    n0 = u_eng.starts;
    u_eng.recal(30, 1'b0, 8'h80);
    settle();
    check(8'(u_eng.starts - n0), 8'h05);
    kerr(8'h1E, 8'h01);
    ask(CMD_STATUS, 8'h04);
    // Keys 20, 30, 40 and 41 now hold errors.
    bad = 64'h0000_0300_4010_0000;
    cmd(CMD_SC_ALL, 8'h00);
    cmd(CMD_G_ERR, 8'h00);
    for (int i = 0; i < 8; i++) begin
      get(b);
      check(b, bad[8*i +: 8]);
    end
    nomore();
    cmd(CMD_SC_ROW, 8'h06);
    ask(CMD_G_ERR, 8'h08);
    cmd(CMD_SC_COL, 8'h05);
    ask(CMD_G_ERR, 8'h03);
    nomore();
    cmd(CMD_SC_KEY, 8'h29);
    ask(CMD_G_ERR, 8'h08);
    ask(CMD_FIRST, NO_KEY);
    key_detect <= 64'h1000;
    ask(CMD_FIRST, 8'h0C);
    key_detect[40] <= 1'b1;
    ask(CMD_FIRST, 8'h8C);
    key_detect[12] <= 1'b0;
    ask(CMD_FIRST, 8'h28);
    key_detect <= 64'h0081_0100_0000_0000;
    ask(CMD_FIRST, 8'hA8);
    key_detect[40] <= 1'b0;
    cmd(CMD_FIRST, 8'h00);
    get(b);
    check(8'(b == 8'hB0 || b == 8'hB7), 8'h01);
    // A new command must cut a long answer short.
    cmd(CMD_G_SIG, 8'h00);
    get(b);
    check(b, want(0, 0));
    xfer(1'b0, ADDR_STAT, 32'h0);
    check(rd[7:0], 8'hBF);
    ask(CMD_STATUS, 8'h05);
    nomore();
    wrap_up();
  end
endmodule
`default_nettype wire
